// ==== core/tlic_pkg.sv ====
// Package for the two-level interrupt combiner: register map and widths.
// Assumes a 32-bit APB slave on core_clk and 32 first-level sources.
package tlic_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned SRC_COUNT   = 32;
  localparam int unsigned ADDR_WIDTH  = 12;
  localparam int unsigned GPIO_PINS   = 28;
  localparam int unsigned GPIO_SINGLE = 11;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFS_NORMAL_PEND  = 12'h000;
  localparam logic [11:0] OFS_SOURCE_MASK  = 12'h004;
  localparam logic [11:0] OFS_LEVEL_SELECT = 12'h008;
  localparam logic [11:0] OFS_FAST_PEND    = 12'h00c;
  localparam logic [11:0] OFS_OVERALL_PEND = 12'h010;
  localparam logic [11:0] OFS_CONTROL      = 12'h014;

  // ==========================================================================
  // Reset values and control fields
  localparam logic [31:0] MASK_RESET   = 32'h00000000;
  localparam logic [31:0] LEVEL_RESET  = 32'h00000000;
  localparam int unsigned CTL_IDLE_BIT = 0;
  localparam logic [31:0] ERR_READ     = 32'h00000000;

endpackage : tlic_pkg

// ==== core/tlic_gpio_merge.sv ====
// Folds the per-pin edge status flags into first-level request lines.
// Assumes flags come from logic on core_clk, so no synchronisers.
`timescale 1ns/1ps
module tlic_gpio_merge #(
  parameter int unsigned PINS   = 28,
  parameter int unsigned SINGLE = 11
) (
  // Edge status flags from the pin unit
  input  wire logic [PINS-1:0]   pinEdgeStatus,
  // Requests: one per low pin, then one shared
  output logic      [SINGLE:0]   gpioReq
);

  // ==========================================================================
  // Merge
  // separate low pins, shared high
  always_comb begin
    gpioReq = {|pinEdgeStatus[PINS-1:SINGLE], pinEdgeStatus[SINGLE-1:0]};
  end

endmodule : tlic_gpio_merge

// ==== core/tlic_top.sv ====
// Two-level interrupt combiner: masking, routing and pending views.
// Assumes an APB master on core_clk and source lines from core_clk logic.
//
// Behaviour
// - Mask each source; route to one output
// - Normal and fast pending hold only enabled, unmasked sources
// - Source reaches normal and fast lines only while unmasked
// - Normal view: unmasked sources routed normal
// - Fast view: unmasked sources routed fast
// - Level select bit picks route per source
// - Request line is OR of unit flags
// - Idle: any enabled request wakes processor
// - Idle wake ignores the mask
// - Pins 10..0 separate, 27..11 shared
// - Overall view read-only, mask ignored
`timescale 1ns/1ps
module tlic_top #(
  parameter int unsigned SRC = 32
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // First-level request lines from units 12 to 31
  input  wire logic [SRC-1:12]       unitReq,
  // Pin edge status flags from the pin unit
  input  wire logic [27:0]           pinEdgeStatus,
  // Processor interrupt lines and wake
  output logic                       normalIrq,
  output logic                       fastInterruptRequest,
  output logic                       idleWake
);

  // ==========================================================================
  // Declarations
  logic [SRC-1:0] sourceMaskSetting_reg;   // 1 = source passes
  logic [SRC-1:0] sourceMaskSetting_next;
  logic [SRC-1:0] levelSelectSetting_reg;  // 1 = fast route
  logic [SRC-1:0] levelSelectSetting_next;
  logic           idleMode_reg;            // Chip in idle
  logic           idleMode_next;
  logic [SRC-1:0] normalPend_reg;          // Normal pending view
  logic [SRC-1:0] normalPend_next;
  logic [SRC-1:0] fastPend_reg;            // Fast pending view
  logic [SRC-1:0] fastPend_next;
  logic [SRC-1:0] overallPend_reg;         // Overall pending view
  logic [SRC-1:0] overallPend_next;
  logic           normalIrq_reg;
  logic           normalIrq_next;
  logic           fastIrq_reg;
  logic           fastIrq_next;
  logic           wake_reg;
  logic           wake_next;
  logic [31:0]    prdata_reg;
  logic [31:0]    prdata_next;
  logic           pslverr_reg;
  logic           pslverr_next;
  logic [11:0]    gpioReq;                 // Merged pin requests
  logic [SRC-1:0] allReq;                  // Every source line
  logic           apbWrite;
  logic           apbRead;
  logic           addrHit;

  // ==========================================================================
  // Pin flag merge
  tlic_gpio_merge #(
    .PINS   (tlic_pkg::GPIO_PINS),
    .SINGLE (tlic_pkg::GPIO_SINGLE)
  ) u_merge (
    .pinEdgeStatus (pinEdgeStatus),
    .gpioReq       (gpioReq)
  );

  // each unit line and the shared pin line is an OR
  // Units hand over already ORed flags; pin flags 27..11 are ORed here, pins 10..0 pass singly.
  // no per-condition enable here
  assign allReq = {unitReq, gpioReq};

  // ==========================================================================
  // APB decode
  // Zero wait states: the access phase always completes on its first edge.
  assign apbWrite = psel && penable && pwrite;
  assign apbRead  = psel && penable && !pwrite;

  // Known offsets
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == tlic_pkg::OFS_NORMAL_PEND)  || (a == tlic_pkg::OFS_SOURCE_MASK) ||
             (a == tlic_pkg::OFS_LEVEL_SELECT) || (a == tlic_pkg::OFS_FAST_PEND)   ||
             (a == tlic_pkg::OFS_OVERALL_PEND) || (a == tlic_pkg::OFS_CONTROL);
  endfunction : mapped

  assign addrHit = mapped(paddr);

  // ==========================================================================
  // Settings next state
  always_comb begin
    sourceMaskSetting_next  = sourceMaskSetting_reg;
    levelSelectSetting_next = levelSelectSetting_reg;
    idleMode_next           = idleMode_reg;
    if (apbWrite) begin
      unique case (paddr)
        tlic_pkg::OFS_SOURCE_MASK: begin
          sourceMaskSetting_next = pwdata;
        end
        tlic_pkg::OFS_LEVEL_SELECT: begin
          levelSelectSetting_next = pwdata;
        end
        tlic_pkg::OFS_CONTROL: begin
          idleMode_next = pwdata[tlic_pkg::CTL_IDLE_BIT];
        end
        // Pending views are read-only; writes dropped
        default: begin
        end
      endcase
    end
  end

  // Settings registers
  // reset values are defined although software must still set them
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sourceMaskSetting_reg  <= tlic_pkg::MASK_RESET;
      levelSelectSetting_reg <= tlic_pkg::LEVEL_RESET;
      idleMode_reg           <= 1'b0;
    end else begin
      sourceMaskSetting_reg  <= sourceMaskSetting_next;
      levelSelectSetting_reg <= levelSelectSetting_next;
      idleMode_reg           <= idleMode_next;
    end
  end

  // ==========================================================================
  // Pending views next state
  // Views follow the live lines, so no clear action is kept here.
  always_comb begin
    overallPend_next = allReq;
    normalPend_next  = allReq & sourceMaskSetting_reg & ~levelSelectSetting_reg;
    fastPend_next    = allReq & sourceMaskSetting_reg & levelSelectSetting_reg;
    normalIrq_next   = |normalPend_next;
    fastIrq_next     = |fastPend_next;
    // wake on any request, mask ignored
    wake_next        = idleMode_reg && (|allReq);
  end

  // Pending registers
  // bits drop when unit flags clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      overallPend_reg <= '0;
      normalPend_reg  <= '0;
      fastPend_reg    <= '0;
      normalIrq_reg   <= 1'b0;
      fastIrq_reg     <= 1'b0;
      wake_reg        <= 1'b0;
    end else begin
      overallPend_reg <= overallPend_next;
      normalPend_reg  <= normalPend_next;
      fastPend_reg    <= fastPend_next;
      normalIrq_reg   <= normalIrq_next;
      fastIrq_reg     <= fastIrq_next;
      wake_reg        <= wake_next;
    end
  end

  // ==========================================================================
  // Read data next state
  // Data is registered during setup so it is stable for the access edge.
  always_comb begin
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      pslverr_next = !addrHit;
      unique case (paddr)
        tlic_pkg::OFS_NORMAL_PEND:  prdata_next = normalPend_reg;
        tlic_pkg::OFS_SOURCE_MASK:  prdata_next = sourceMaskSetting_reg;
        tlic_pkg::OFS_LEVEL_SELECT: prdata_next = levelSelectSetting_reg;
        tlic_pkg::OFS_FAST_PEND:    prdata_next = fastPend_reg;
        tlic_pkg::OFS_OVERALL_PEND: prdata_next = overallPend_reg;
        tlic_pkg::OFS_CONTROL:      prdata_next = {31'h00000000, idleMode_reg};
        default:                    prdata_next = tlic_pkg::ERR_READ;
      endcase
    end else if (apbRead || apbWrite) begin
      // Hold through the access edge
      prdata_next  = prdata_reg;
      pslverr_next = pslverr_reg;
    end
  end

  // Read data registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata               = prdata_reg;
  assign pready               = 1'b1;
  assign pslverr              = pslverr_reg & psel & penable;
  assign normalIrq            = normalIrq_reg;
  assign fastInterruptRequest = fastIrq_reg;
  assign idleWake             = wake_reg;

endmodule : tlic_top

// ==== verif/tlic_chk.sv ====
// Checker: port-level properties of the interrupt combiner.
// Assumes it is bound onto tlic_top and sees its ports only.
`timescale 1ns/1ps
module tlic_chk #(
  parameter int unsigned SRC = 32
) (
  // Clock, reset and bus
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      prdata,
  // Sources and processor lines
  input wire logic [SRC-1:12]  unitReq,
  input wire logic [27:0]      pinEdgeStatus,
  input wire logic             normalIrq,
  input wire logic             fastInterruptRequest,
  input wire logic             idleWake
);
  // ==========================================================================
  // Helpers
  // Expected source vector: shared pin group folds into bit 11
  wire logic [31:0] srcVec = {unitReq, |pinEdgeStatus[27:11], pinEdgeStatus[10:0]};
  wire logic        rdAcc  = psel && penable && !pwrite;  // Read access phase
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Sources unchanged long enough for a registered view to settle
  sequence s_steady;
    srcVec == $past(srcVec) && srcVec == $past(srcVec, 2) && srcVec == $past(srcVec, 3);
  endsequence
  sequence s_viewRead;
    rdAcc && (paddr == tlic_pkg::OFS_NORMAL_PEND || paddr == tlic_pkg::OFS_FAST_PEND);
  endsequence
  // ==========================================================================
  // Properties
  property p_quiet; srcVec == 32'h0 |=> !normalIrq && !fastInterruptRequest; endproperty
  a_quiet: assert property (p_quiet) else $error("irq without any source");
  property p_idleQuiet; srcVec == 32'h0 |=> !idleWake; endproperty
  a_idleQuiet: assert property (p_idleQuiet) else $error("wake without source");
  property p_wakeCause; idleWake |-> $past(srcVec) != 32'h0; endproperty
  a_wakeCause: assert property (p_wakeCause) else $error("wake has no cause");
  property p_normCause; $rose(normalIrq) |-> $past(srcVec) != 32'h0; endproperty
  a_normCause: assert property (p_normCause) else $error("normal irq uncaused");
  property p_fastCause; fastInterruptRequest |-> $past(srcVec) != 32'h0; endproperty
  a_fastCause: assert property (p_fastCause) else $error("fast irq uncaused");
  property p_overall;
    (rdAcc && paddr == tlic_pkg::OFS_OVERALL_PEND) ##0 s_steady |-> prdata == srcVec;
  endproperty
  a_overall: assert property (p_overall) else $error("overall view wrong");
  property p_subset; s_viewRead ##0 s_steady |-> (prdata & ~srcVec) == 32'h0; endproperty
  a_subset: assert property (p_subset) else $error("view shows idle source");
  property p_excl;
    $onehot(srcVec) && srcVec == $past(srcVec) |-> !(normalIrq && fastInterruptRequest);
  endproperty
  a_excl: assert property (p_excl) else $error("one source on both lines");
endmodule : tlic_chk

bind tlic_top tlic_chk #(.SRC(SRC)) u_chk (.core_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .prdata, .unitReq, .pinEdgeStatus, .normalIrq, .fastInterruptRequest, .idleWake);

// ==== verif/tlic_cpu_model.sv ====
// Processor-side model: counts entries into each interrupt handler.
// Assumes level interrupt lines on core_clk.
`timescale 1ns/1ps
module tlic_cpu_model (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Interrupt lines
  input wire logic        normalIrq,
  input wire logic        fastInterruptRequest,
  // Handler entry counts
  output logic [7:0]      normalCnt_reg,
  output logic [7:0]      fastCnt_reg
);
  logic normPrev_reg, fastPrev_reg;  // Lines seen last cycle
  // A rising line is one handler entry; levels alone would over-count
  always_ff @(posedge core_clk) begin
    normPrev_reg  <= rst ? 1'b0 : normalIrq;
    fastPrev_reg  <= rst ? 1'b0 : fastInterruptRequest;
    normalCnt_reg <= rst ? 8'h00 : normalCnt_reg + 8'(normalIrq && !normPrev_reg);
    fastCnt_reg   <= rst ? 8'h00 : fastCnt_reg + 8'(fastInterruptRequest && !fastPrev_reg);
  end
endmodule : tlic_cpu_model

// ==== verif/two_level_interrupt_combiner_test.sv ====
// Testbench: APB sequences against the combiner with expected views.
// Assumes tlic_top, the checker bind and the processor model.
`timescale 1ns/1ps
module two_level_interrupt_combiner_test;
  logic        core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, normalIrq, fastInterruptRequest, idleWake;
  logic [31:12] unitReq = '0;
  logic [27:0] pinEdgeStatus = '0;
  logic [7:0]  normalCnt, fastCnt;
  int          nErrors = 0, nTests = 0;
  always #12.5 core_clk = ~core_clk;
  tlic_top DUT (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .unitReq, .pinEdgeStatus, .normalIrq, .fastInterruptRequest, .idleWake);
  tlic_cpu_model cpu (.core_clk, .rst, .normalIrq, .fastInterruptRequest,
    .normalCnt_reg(normalCnt), .fastCnt_reg(fastCnt));
  task automatic endOfTest();
    $display("Comparisons %0d, mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : endOfTest
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nErrors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // One APB transfer; read data and error are taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      nErrors++;
      endOfTest();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  initial begin
    tick(6);
    rst <= 1'b0;
    tick(1);
    apb(1'b0, tlic_pkg::OFS_SOURCE_MASK, 32'h0);
    chk(rd, tlic_pkg::MASK_RESET);
    apb(1'b0, tlic_pkg::OFS_LEVEL_SELECT, 32'h0);
    chk(rd, tlic_pkg::LEVEL_RESET);
    apb(1'b1, tlic_pkg::OFS_SOURCE_MASK, 32'hffffffff);
    // unit raises its own ORed line
    unitReq[20] <= 1'b1;
    tick(2);
    // handler finds the unit from the view
    apb(1'b0, tlic_pkg::OFS_NORMAL_PEND, 32'h0);
    chk(rd, 32'h00100000);
    chk(normalIrq, 1'b1);
    apb(1'b1, tlic_pkg::OFS_LEVEL_SELECT, 32'h00100000);
    apb(1'b0, tlic_pkg::OFS_FAST_PEND, 32'h0);
    chk(rd, 32'h00100000);
    apb(1'b0, tlic_pkg::OFS_NORMAL_PEND, 32'h0);
    chk(rd, 32'h0);
    chk({normalIrq, fastInterruptRequest}, 2'b01);
    $display("Test routing done");
    apb(1'b1, tlic_pkg::OFS_SOURCE_MASK, 32'hffefffff);
    apb(1'b0, tlic_pkg::OFS_FAST_PEND, 32'h0);
    chk(rd, 32'h0);
    chk(fastInterruptRequest, 1'b0);
    apb(1'b1, tlic_pkg::OFS_OVERALL_PEND, 32'h0);
    chk(err, 1'b0);
    apb(1'b0, tlic_pkg::OFS_OVERALL_PEND, 32'h0);
    chk(rd, 32'h00100000);
    unitReq[20] <= 1'b0;
    pinEdgeStatus <= 28'h8000020;
    apb(1'b1, tlic_pkg::OFS_SOURCE_MASK, 32'hffffffff);
    apb(1'b0, tlic_pkg::OFS_OVERALL_PEND, 32'h0);
    chk(rd, 32'h00000820);
    apb(1'b0, tlic_pkg::OFS_NORMAL_PEND, 32'h0);
    chk(rd, 32'h00000820);
    pinEdgeStatus <= 28'h0;
    tick(2);
    chk(normalIrq, 1'b0);
    $display("Test masking done");
    apb(1'b1, tlic_pkg::OFS_SOURCE_MASK, 32'h0);
    apb(1'b1, tlic_pkg::OFS_CONTROL, 32'h00000001);
    unitReq[31] <= 1'b1;
    tick(2);
    chk({idleWake, normalIrq, fastInterruptRequest}, 3'b100);
    unitReq[31] <= 1'b0;
    tick(2);
    chk(idleWake, 1'b0);
    apb(1'b0, 12'h020, 32'h0);
    // Error flag and read data compared apart: together they exceed one word
    chk(err, 1'b1);
    chk(rd, tlic_pkg::ERR_READ);
    chk({normalCnt, fastCnt}, 16'h0201);
    $display("Test idle and bus done");
    endOfTest();
  end
endmodule : two_level_interrupt_combiner_test
